// File: rtl/can_ctrl_pkg.sv
// Constants, field layout and offsets for the CAN error count and message center control block
// Function
// (RULE_01) Keep 8-bit transmit and receive error counts
// (RULE_02) Transmit count writes need init mode, bus on
// (RULE_03) Accepted write loads both counters together
// (RULE_04) Writing zero clears error-count-exceeded flag
// (RULE_05) Hardware and soft reset clear both counters
// (RULE_06) Report active, warning, passive from transmit count
// (RULE_07) Transmit count past 255 enters bus-off
// (RULE_08) Not-ready center skipped for all traffic
// (RULE_09) Resets clear ready; software holds until init
// (RULE_10) Per-center ready change leaves others running
// (RULE_11) Transmit done raises request when enabled
// (RULE_12) Receive stored raises request when enabled
// (RULE_13) Software alone clears the interrupt request
// (RULE_14) Requests reach CPU only with global enable
// (RULE_15) Center 15 ignores transmit enable and request
// (RULE_16) Remote request sets pending; transmit done clears
// (RULE_17) Transmit center answers only updated, uninhibited data
// (RULE_18) Receive center sets pending, never clears it
// (RULE_19) Control bits writable; pending clear-only; reset zero
// (RULE_20) CPU transmit request held until transmission completes
// (RULE_21) Soft reset and system reset clear transmit request
// (RULE_22) Remote request on transmit center sets transmit request
package can_ctrl_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] TX_ERR_ADDR      = 8'hA6;  // Transmit error counter
  localparam logic [7:0] RX_ERR_ADDR      = 8'hA7;  // Receive error counter
  localparam logic [7:0] CENTER1_ADDR     = 8'hAB;  // First message center control
  localparam logic [7:0] STATUS_ADDR      = 8'hBA;  // Error state summary

  // Message center control byte layout
  localparam int CTL_READY  = 7;  // Center ready
  localparam int CTL_TXIE   = 6;  // Transmit interrupt enable
  localparam int CTL_RXIE   = 5;  // Receive interrupt enable
  localparam int CTL_IRQ    = 4;  // Interrupt request
  localparam int CTL_REMOTE = 3;  // Remote request pending
  localparam int CTL_CPUTX  = 2;  // CPU transmit request
  localparam int CTL_INH    = 1;  // Overwrite or inhibit, shown from outside
  localparam int CTL_UPD    = 0;  // Data updated, shown from outside

  // Status byte layout
  localparam int ST_BUSOFF  = 7;  // Bus off
  localparam int ST_EXCEED  = 6;  // Error count exceeded
  localparam int ST_PASSIVE = 1;  // Error passive
  localparam int ST_WARN    = 0;  // Warning level

  // Reset values and thresholds
  localparam logic [7:0] CTL_RESET     = 8'h00;  // Control byte after reset
  localparam logic [7:0] ERR_RESET     = 8'h00;  // Counters after reset
  localparam logic [7:0] ERR_WARN_LVL  = 8'h60;  // 96: warning level
  localparam logic [7:0] ERR_PASS_LVL  = 8'h80;  // 128: error passive
  localparam logic [8:0] ERR_OFF_LVL   = 9'h0FF; // Above 255: bus off
  localparam logic [7:0] ERR_MAX       = 8'hFF;  // Counter ceiling
  localparam logic [7:0] ERR_ZERO      = 8'h00;  // Write value that clears flag
  localparam logic [7:0] ERR_ONE       = 8'h01;  // Decrement step

  // Center numbering
  localparam int NUM_CENTERS    = 15;  // Message centers
  localparam int RX_ONLY_CENTER = 15;  // Receive-only center

endpackage : can_ctrl_pkg

// File: rtl/msg_center_ctrl.sv
// Control bits of one message center
`timescale 1ns/1ps
module msg_center_ctrl #(
  parameter bit RX_ONLY = 1'b0  // Center can never transmit
) (
  // Clock and resets
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       softReset,
  // Register write
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  // Engine events and message format state
  input  wire logic       txDone,
  input  wire logic       rxStored,
  input  wire logic       remoteReq,
  input  wire logic       isTransmit,
  input  wire logic       dataUpdated,
  input  wire logic       txInhibit,
  // Stored bits and derived requests
  output logic      [5:0] ctlBits,
  output logic            txWanted,
  output logic            remoteAnswer
);
  import can_ctrl_pkg::*;

  logic ready_r, txIe_r, rxIe_r, irq_r, remote_r, cpuTx_r;  // Stored bits
  logic ready_nxt, txIe_nxt, rxIe_nxt, irq_nxt, remote_nxt, cpuTx_nxt;

  // Events only count while the center is ready
  wire txEv     = ready_r & txDone & ~RX_ONLY;           // RULE_08 RULE_15
  wire rxEv     = ready_r & rxStored;                    // RULE_08
  wire remEv    = ready_r & remoteReq;                   // RULE_08
  wire irqSet   = (txEv & txIe_r & ~RX_ONLY) | (rxEv & rxIe_r);  // RULE_11 RULE_12 RULE_15
  wire cpuTxSet = remEv & isTransmit & ~RX_ONLY;         // RULE_22

  // Next-state: hardware sets win over software clears
  always_comb begin
    ready_nxt  = wrEn ? wrData[CTL_READY] : ready_r;     // RULE_10 RULE_19
    txIe_nxt   = wrEn ? wrData[CTL_TXIE] : txIe_r;       // RULE_19
    rxIe_nxt   = wrEn ? wrData[CTL_RXIE] : rxIe_r;       // RULE_19
    irq_nxt    = (wrEn ? wrData[CTL_IRQ] : irq_r) | irqSet;  // RULE_13 RULE_19
    // Pending remote: software may only clear, transmit done on a transmit center clears
    remote_nxt = remote_r & ~(wrEn & ~wrData[CTL_REMOTE]);   // RULE_19
    if (txEv && isTransmit) begin
      remote_nxt = 1'b0;                                 // RULE_16 RULE_18
    end
    remote_nxt = remote_nxt | remEv;                     // RULE_16 RULE_18
    // Transmit request held until completion
    cpuTx_nxt  = wrEn ? wrData[CTL_CPUTX] : cpuTx_r;     // RULE_20
    if (txEv) begin
      cpuTx_nxt = 1'b0;                                  // RULE_20
    end
    cpuTx_nxt  = (cpuTx_nxt | cpuTxSet) & ~RX_ONLY;      // RULE_15 RULE_22
  end

  // Bit storage; soft reset returns all bits to zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {ready_r, txIe_r, rxIe_r, irq_r, remote_r, cpuTx_r} <= 6'h00;  // RULE_09 RULE_21
    end else if (softReset) begin
      {ready_r, txIe_r, rxIe_r, irq_r, remote_r, cpuTx_r} <= 6'h00;  // RULE_09 RULE_21
    end else begin
      ready_r  <= ready_nxt;
      txIe_r   <= txIe_nxt;
      rxIe_r   <= rxIe_nxt;
      irq_r    <= irq_nxt;
      remote_r <= remote_nxt;
      cpuTx_r  <= cpuTx_nxt;
    end
  end

  assign ctlBits      = {ready_r, txIe_r, rxIe_r, irq_r, remote_r, cpuTx_r};
  // Engine may send this center's frame
  assign txWanted     = ready_r & cpuTx_r & ~(isTransmit & txInhibit);  // RULE_08
  // Remote request answered only with fresh, uninhibited data
  assign remoteAnswer = ready_r & remote_r & isTransmit & dataUpdated
                        & ~txInhibit & ~RX_ONLY;         // RULE_17
endmodule : msg_center_ctrl

// File: rtl/can_err_msg_ctrl.sv
// Error counters, bus state and message center control registers
`timescale 1ns/1ps
module can_err_msg_ctrl #(
  parameter int NCENTER  = can_ctrl_pkg::NUM_CENTERS,     // Message centers
  parameter int RXONLY   = can_ctrl_pkg::RX_ONLY_CENTER,  // Receive-only center number
  parameter int TX_STEP  = 8                              // Transmit error increment
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Special function register port
  input  wire logic [7:0]         sfrAddr,
  input  wire logic               sfrWrite,
  input  wire logic [7:0]         sfrWdata,
  output logic      [7:0]         sfrRdata,
  // Controller mode bits
  input  wire logic               swInitMode,
  input  wire logic               controllerSoftReset,
  input  wire logic               globalIrqEnable,
  // Error events from the protocol engine
  input  wire logic               txErrUp,
  input  wire logic               txErrDown,
  input  wire logic               rxErrUp,
  input  wire logic               rxErrDown,
  // Per-center events and format state, bit 0 is center 1
  input  wire logic [NCENTER-1:0] txDone,
  input  wire logic [NCENTER-1:0] rxStored,
  input  wire logic [NCENTER-1:0] remoteReq,
  input  wire logic [NCENTER-1:0] isTransmit,
  input  wire logic [NCENTER-1:0] dataUpdated,
  input  wire logic [NCENTER-1:0] overwriteOrInhibit,
  // Bus state
  output logic                    busOff,
  output logic                    errWarning,
  output logic                    errPassive,
  output logic                    errorCountExceeded,
  // Toward the engine and the CPU interrupt logic
  output logic      [NCENTER-1:0] centerReady,
  output logic      [NCENTER-1:0] txPending,
  output logic      [NCENTER-1:0] remoteAnswerEn,
  output logic                    canIrq
);
  import can_ctrl_pkg::*;

  // Parameter check: a sixteenth center would land on the status address
  if (NCENTER < 1 || NCENTER > NUM_CENTERS || RXONLY < 1 || RXONLY > NCENTER
      || TX_STEP < 1 || TX_STEP > 255) begin : g_bad_params
    $error("can_err_msg_ctrl: unsupported parameters");
  end

  localparam logic [8:0] TX_STEP9 = 9'(TX_STEP);  // Increment at sum width

  // Error counters and flags
  logic [7:0] txErr_r, txErr_nxt;        // Transmit error count
  logic [7:0] rxErr_r, rxErr_nxt;        // Receive error count
  logic       busOff_r, busOff_nxt;      // Bus-off state
  logic       exceed_r, exceed_nxt;      // Error count exceeded
  logic       warn_r, passive_r;         // Registered bus-state outputs
  logic [7:0] rdata_r;                   // Read data
  logic       irq_r;                     // Interrupt toward the CPU
  logic [NCENTER-1:0] ready_r;           // Registered center ready
  logic [NCENTER-1:0] txPend_r;          // Registered transmit wish
  logic [NCENTER-1:0] remAns_r;          // Registered remote answer enable

  // Per-center wires
  logic [5:0]         ctl    [NCENTER];  // Stored control bits per center
  logic [NCENTER-1:0] ctlWr;             // Write strobe per center
  logic [NCENTER-1:0] irqVec;            // Interrupt request per center
  logic [NCENTER-1:0] txWant;            // Transmit wish per center
  logic [NCENTER-1:0] remAns;            // Remote answer per center

  // Address decode
  wire txErrHit  = (sfrAddr == TX_ERR_ADDR);
  wire rxErrHit  = (sfrAddr == RX_ERR_ADDR);
  wire statusHit = (sfrAddr == STATUS_ADDR);
  // Counter write accepted only in init mode while bus on
  wire txErrWrOk = sfrWrite & txErrHit & swInitMode & ~busOff_r;  // RULE_02
  wire wrZero    = txErrWrOk & (sfrWdata == ERR_ZERO);            // RULE_04

  // Sum kept one bit wider to see passing 255
  wire [8:0] txSum   = {1'b0, txErr_r} + TX_STEP9;
  wire       txOver  = txErrUp & (txSum > ERR_OFF_LVL);           // RULE_07
  wire       rxAtMax = (rxErr_r == ERR_MAX);
  wire       txAtMin = (txErr_r == ERR_RESET);
  wire       rxAtMin = (rxErr_r == ERR_RESET);

  // Counter next values
  always_comb begin
    txErr_nxt = txErr_r;
    rxErr_nxt = rxErr_r;
    if (txErrWrOk) begin
      // Software load copies the value into both counters
      txErr_nxt = sfrWdata;                                       // RULE_03
      rxErr_nxt = sfrWdata;                                       // RULE_03
    end else begin
      if (txErrUp && !busOff_r) begin
        // Saturate at the top once bus off is reached
        txErr_nxt = txOver ? ERR_MAX : txSum[7:0];                // RULE_01
      end else if (txErrDown && !txAtMin) begin
        txErr_nxt = txErr_r - ERR_ONE;                            // RULE_01
      end
      if (rxErrUp && !rxAtMax) begin
        rxErr_nxt = rxErr_r + ERR_ONE;                            // RULE_01
      end else if (rxErrDown && !rxAtMin) begin
        rxErr_nxt = rxErr_r - ERR_ONE;                            // RULE_01
      end
    end
  end

  // Flag next values: the clearing write beats a count event in the same cycle
  always_comb begin
    busOff_nxt = busOff_r | (txOver & ~busOff_r);                 // RULE_07
    exceed_nxt = exceed_r & ~wrZero;                              // RULE_04
    if (txErr_nxt >= ERR_WARN_LVL && (txErrUp || rxErrUp)) begin
      exceed_nxt = 1'b1;
    end
    if (rxErr_nxt >= ERR_WARN_LVL && rxErrUp) begin
      exceed_nxt = 1'b1;
    end
  end

  // Counters and flags; soft reset clears them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txErr_r  <= ERR_RESET;                                      // RULE_05
      rxErr_r  <= ERR_RESET;                                      // RULE_05
      busOff_r <= 1'b0;
      exceed_r <= 1'b0;
    end else if (controllerSoftReset) begin
      txErr_r  <= ERR_RESET;                                      // RULE_05
      rxErr_r  <= ERR_RESET;                                      // RULE_05
      busOff_r <= 1'b0;
      exceed_r <= 1'b0;
    end else begin
      txErr_r  <= txErr_nxt;
      rxErr_r  <= rxErr_nxt;
      busOff_r <= busOff_nxt;
      exceed_r <= exceed_nxt;
    end
  end

  // Bus state decode from the stored transmit count
  wire warnNow    = ~busOff_r & (txErr_r >= ERR_WARN_LVL) & (txErr_r < ERR_PASS_LVL);  // RULE_06
  wire passiveNow = ~busOff_r & (txErr_r >= ERR_PASS_LVL);                             // RULE_06

  // One control block per message center
  genvar gi;
  generate
    for (gi = 0; gi < NCENTER; gi++) begin : g_center
      // Each center owns one register address
      assign ctlWr[gi] = sfrWrite & (sfrAddr == 8'(CENTER1_ADDR + gi));
      msg_center_ctrl #(
        .RX_ONLY (gi + 1 == RXONLY)
      ) u_center (
        .clk_sys      (clk_sys),
        .rst_n        (rst_n),
        .softReset    (controllerSoftReset),
        .wrEn         (ctlWr[gi]),
        .wrData       (sfrWdata),
        .txDone       (txDone[gi]),
        .rxStored     (rxStored[gi]),
        .remoteReq    (remoteReq[gi]),
        .isTransmit   (isTransmit[gi]),
        .dataUpdated  (dataUpdated[gi]),
        .txInhibit    (overwriteOrInhibit[gi]),
        .ctlBits      (ctl[gi]),
        .txWanted     (txWant[gi]),
        .remoteAnswer (remAns[gi])
      );
      assign irqVec[gi] = ctl[gi][CTL_IRQ - 2];
    end
  endgenerate

  // Read multiplexer; unmapped addresses read zero
  logic [7:0] rdMux;
  always_comb begin
    rdMux = 8'h00;
    if (txErrHit) begin
      rdMux = txErr_r;                                            // RULE_01
    end else if (rxErrHit) begin
      rdMux = rxErr_r;                                            // RULE_01
    end else if (statusHit) begin
      rdMux[ST_BUSOFF]  = busOff_r;
      rdMux[ST_EXCEED]  = exceed_r;
      rdMux[ST_PASSIVE] = passiveNow;
      rdMux[ST_WARN]    = warnNow;
    end
    for (int i = 0; i < NCENTER; i++) begin
      if (sfrAddr == 8'(CENTER1_ADDR + i)) begin
        rdMux = {ctl[i], overwriteOrInhibit[i], dataUpdated[i]};
      end
    end
  end

  // Output registers; bus state drops in the cycle bus off is entered so states never overlap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r   <= 8'h00;
      warn_r    <= 1'b0;
      passive_r <= 1'b0;
      irq_r     <= 1'b0;
      ready_r   <= '0;
      txPend_r  <= '0;
      remAns_r  <= '0;
    end else begin
      rdata_r   <= rdMux;
      warn_r    <= warnNow & ~busOff_nxt;                         // RULE_06
      passive_r <= passiveNow & ~busOff_nxt;                      // RULE_06
      irq_r     <= globalIrqEnable & (|irqVec);                   // RULE_14
      ready_r   <= centerReadyVec();                              // RULE_10
      txPend_r  <= txWant;                                        // RULE_08
      remAns_r  <= remAns;                                        // RULE_17
    end
  end

  // Collect ready bits from every center
  function automatic logic [NCENTER-1:0] centerReadyVec();
    logic [NCENTER-1:0] v;
    v = '0;
    for (int i = 0; i < NCENTER; i++) begin
      v[i] = ctl[i][CTL_READY - 2];
    end
    return v;
  endfunction : centerReadyVec

  assign sfrRdata           = rdata_r;
  assign busOff             = busOff_r;
  assign errWarning         = warn_r;
  assign errPassive         = passive_r;
  assign errorCountExceeded = exceed_r;
  assign centerReady        = ready_r;
  assign txPending          = txPend_r;
  assign remoteAnswerEn     = remAns_r;
  assign canIrq             = irq_r;
endmodule : can_err_msg_ctrl

// File: dv/can_err_msg_ctrl_assertions.sv
// Concurrent checks on the error counter and message center control ports
`timescale 1ns/1ps
module can_err_msg_ctrl_assertions
  import can_ctrl_pkg::*;
#(
  parameter int NCENTER = 15,  // Message centers
  parameter int RXONLY  = 15   // Receive-only center number
) (
  // Clock, reset and register port
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire logic [7:0]         sfrAddr,
  input wire logic               sfrWrite,
  input wire logic [7:0]         sfrWdata,
  input wire logic [7:0]         sfrRdata,
  // Mode bits and engine inputs
  input wire logic               swInitMode,
  input wire logic               controllerSoftReset,
  input wire logic               globalIrqEnable,
  input wire logic               txErrUp,
  input wire logic               txErrDown,
  input wire logic [NCENTER-1:0] isTransmit,
  input wire logic [NCENTER-1:0] dataUpdated,
  input wire logic [NCENTER-1:0] overwriteOrInhibit,
  // Outputs under watch
  input wire logic               busOff,
  input wire logic               errWarning,
  input wire logic               errPassive,
  input wire logic               errorCountExceeded,
  input wire logic [NCENTER-1:0] centerReady,
  input wire logic [NCENTER-1:0] txPending,
  input wire logic [NCENTER-1:0] remoteAnswerEn,
  input wire logic               canIrq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic txWrOk;  // Counter write that must be accepted, no transmit count event beside it
  assign txWrOk = sfrWrite && sfrAddr == TX_ERR_ADDR && swInitMode && !busOff && !controllerSoftReset
                  && !txErrUp && !txErrDown;
  wr_loads_count_a: assert property (txWrOk ##1 (sfrAddr == TX_ERR_ADDR && !txErrUp && !txErrDown)
    |=> sfrRdata == $past(sfrWdata, 2)) else $error("Accepted counter write not read back");
  zero_clears_flag_a: assert property (txWrOk && sfrWdata == ERR_ZERO |-> ##[1:2] !errorCountExceeded)
    else $error("Zero write left exceeded flag set");
  one_state_a: assert property ($onehot0({busOff, errPassive, errWarning}))
    else $error("Two bus states at once");
  busoff_sticky_a: assert property (busOff && !controllerSoftReset |=> busOff)
    else $error("Bus off left without reset");
  busoff_cause_a: assert property ($rose(busOff) |-> $past(txErrUp) || $past(txErrUp, 2))
    else $error("Bus off without transmit error step");
  soft_clear_a: assert property (controllerSoftReset |-> ##2 (!busOff && !errWarning && !errPassive
    && !errorCountExceeded && centerReady == '0 && txPending == '0 && !canIrq)) else $error("Soft reset left state");
  irq_gate_a: assert property (!globalIrqEnable |=> !canIrq)
    else $error("Interrupt passed with global enable low");
  rx_only_quiet_a: assert property (!txPending[RXONLY-1] && !remoteAnswerEn[RXONLY-1])
    else $error("Receive-only center asks to send");
  ready_gates_a: assert property (((txPending | remoteAnswerEn) & ~centerReady) == '0)
    else $error("Unready center active");
  answer_cond_a: assert property ((remoteAnswerEn & ~$past(isTransmit & dataUpdated & ~overwriteOrInhibit)) == '0)
    else $error("Remote answer without fresh uninhibited data");
  cover property ($rose(busOff));
  cover property ($rose(canIrq));
  cover property (remoteAnswerEn != '0);
endmodule : can_err_msg_ctrl_assertions

// File: dv/can_node_model.sv
// Protocol engine and remote node stand-in: one-cycle event pulses on command
`timescale 1ns/1ps
module can_node_model #(
  parameter int N = 15  // Message centers
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  // Command: 0 sent, 1 stored, 2 remote request, 3 to 6 error steps
  input  wire logic         cmdGo,
  input  wire logic [2:0]   cmdKind,
  input  wire logic [3:0]   cmdCenter,
  // Pulses toward the controller; in the per-center vectors bit 0 is center 1, errEv has one bit per error step
  output logic      [N-1:0] txDone,
  output logic      [N-1:0] rxStored,
  output logic      [N-1:0] remoteReq,
  output logic      [3:0]   errEv
);
  logic [N-1:0] sel;  // Addressed center, one-hot
  assign sel = N'(1) << (cmdCenter - 4'h1);
  // Each event lasts one cycle, lines idle low between events
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {txDone, rxStored, remoteReq, errEv} <= '0;
    end else begin
      txDone    <= (cmdGo && cmdKind == 3'h0) ? sel : '0;
      rxStored  <= (cmdGo && cmdKind == 3'h1) ? sel : '0;
      remoteReq <= (cmdGo && cmdKind == 3'h2) ? sel : '0;
      errEv     <= (cmdGo && cmdKind >= 3'h3) ? 4'h1 << (cmdKind - 3'h3) : 4'h0;
    end
  end
endmodule : can_node_model

// File: dv/can_err_msg_ctrl_bench.sv
// Self-checking bench for the error counter and message center control block
`timescale 1ns/1ps
`define CHK(g, e) begin samplesChecked++; if ((g) !== (e)) begin nFail++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module can_err_msg_ctrl_bench;
  import can_ctrl_pkg::*;
  // Clock, reset, register port and mode bits
  logic        clk_sys = 1'b0, rst_n = 1'b0, sfrWrite = 1'b0, cmdGo = 1'b0;
  logic [7:0]  sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
  logic        swInitMode = 1'b0, controllerSoftReset = 1'b0, globalIrqEnable = 1'b0;
  logic [14:0] isTransmit = '0, dataUpdated = '0, overwriteOrInhibit = '0, txDone, rxStored, remoteReq;
  logic [2:0]  cmdKind = 3'h0;
  logic [3:0]  cmdCenter = 4'h1, errEv;
  // Outputs under check
  logic        busOff, errWarning, errPassive, errorCountExceeded, canIrq;
  logic [14:0] centerReady, txPending, remoteAnswerEn;
  // Reference model state and bookkeeping
  int          txc = 0, rxc = 0, nFail = 0, samplesChecked = 0, cycles = 0, c, d;
  logic        boffM = 1'b0, excM = 1'b0;
  logic [7:0]  lvl [6] = '{8'h00, 8'h5F, 8'h60, 8'h7F, 8'h80, 8'hFF};
  always #10 clk_sys = ~clk_sys;
  can_err_msg_ctrl dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
    .sfrRdata(sfrRdata), .swInitMode(swInitMode), .controllerSoftReset(controllerSoftReset),
    .globalIrqEnable(globalIrqEnable), .txErrUp(errEv[0]), .txErrDown(errEv[1]), .rxErrUp(errEv[2]),
    .rxErrDown(errEv[3]), .txDone(txDone), .rxStored(rxStored), .remoteReq(remoteReq),
    .isTransmit(isTransmit), .dataUpdated(dataUpdated), .overwriteOrInhibit(overwriteOrInhibit),
    .busOff(busOff), .errWarning(errWarning), .errPassive(errPassive), .errorCountExceeded(errorCountExceeded),
    .centerReady(centerReady), .txPending(txPending), .remoteAnswerEn(remoteAnswerEn), .canIrq(canIrq));
  can_node_model node_u (.clk_sys(clk_sys), .rst_n(rst_n), .cmdGo(cmdGo), .cmdKind(cmdKind),
    .cmdCenter(cmdCenter), .txDone(txDone), .rxStored(rxStored), .remoteReq(remoteReq), .errEv(errEv));
  // Center control address and expected status byte
  function automatic logic [7:0] caddr(input int n);
    return CENTER1_ADDR + 8'(n - 1);
  endfunction : caddr
  function automatic logic [7:0] stat();
    return {boffM, excM, 4'h0, txc >= 128 && !boffM, txc >= 96 && txc < 128 && !boffM};
  endfunction : stat
  // One register write, one register read with compare
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    sfrAddr <= a;
    sfrWrite <= 1'b1;
    sfrWdata <= v;
    @(posedge clk_sys);
    sfrWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    sfrAddr <= a;
    @(posedge clk_sys);
    #1;
    `CHK(sfrRdata, e)
  endtask : rd
  // Event through the node model; returns once derived outputs settled
  task automatic ev(input logic [2:0] k, input int n);
    @(posedge clk_sys);
    cmdGo <= 1'b1;
    cmdKind <= k;
    cmdCenter <= 4'(n);
    @(posedge clk_sys);
    cmdGo <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : ev
  // Counter write and transmit error step, mirrored in the model
  task automatic wtx(input logic [7:0] v);
    wr(TX_ERR_ADDR, v);
    if (swInitMode && !boffM) begin
      txc = v;
      rxc = v;
      excM = excM && v != 8'h00;
    end
  endtask : wtx
  task automatic txUp();
    ev(3'h3, 1);
    txc += 8;
    boffM = boffM || txc > 255;
    txc = (txc > 255) ? 255 : txc;
    excM = excM || txc >= 96;
  endtask : txUp
  task automatic softRst();
    @(posedge clk_sys);
    controllerSoftReset <= 1'b1;
    @(posedge clk_sys);
    controllerSoftReset <= 1'b0;
    {txc, rxc, boffM, excM} = '0;
  endtask : softRst
  task automatic completeRun();
    $display("Checks %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : completeRun
  // Hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      nFail++;
      completeRun();
    end
  end
  // Main sequence
  initial begin
    void'($urandom(23544));
    lvl[0] = 8'($urandom_range(255));
    c = $urandom_range(14, 1);
    d = c % 14 + 1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int n = 1; n <= NUM_CENTERS; n++) rd(caddr(n), CTL_RESET);
    rd(RX_ERR_ADDR, ERR_RESET);
    rd(8'hA5, 8'h00);
    wtx(lvl[0] ^ 8'h5A);
    rd(TX_ERR_ADDR, 8'(txc));
    @(posedge clk_sys) swInitMode <= 1'b1;
    foreach (lvl[i]) begin
      wtx(lvl[i]);
      rd(RX_ERR_ADDR, 8'(rxc));
      rd(STATUS_ADDR, stat());
      `CHK({errPassive, errWarning}, stat() & 8'h03)
    end
    wr(RX_ERR_ADDR, 8'h33);
    rd(RX_ERR_ADDR, 8'(rxc));
    wtx(8'h60);
    txUp();
    rd(STATUS_ADDR, stat());
    wtx(8'h00);
    rd(STATUS_ADDR, stat());
    wtx(8'hF8);
    ev(3'h4, 1);
    txc--;
    ev(3'h5, 1);
    rxc++;
    excM = excM || rxc >= 96;
    rd(RX_ERR_ADDR, 8'(rxc));
    txUp();
    txUp();
    rd(STATUS_ADDR, stat());
    `CHK({busOff, errorCountExceeded}, stat() >> 6)
    wtx(8'h00);
    rd(TX_ERR_ADDR, 8'(txc));
    softRst();
    rd(TX_ERR_ADDR, 8'(txc));
    rd(STATUS_ADDR, stat());
    wr(caddr(c), 8'hE0);
    ev(3'h1, c);
    rd(caddr(c), 8'hF0);
    `CHK(canIrq, 1'b0)
    @(posedge clk_sys) globalIrqEnable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 `CHK(canIrq, 1'b1)
    wr(caddr(c), 8'hE0);
    ev(3'h0, c);
    rd(caddr(c), 8'hF0);
    wr(caddr(c), 8'h80);
    ev(3'h1, c);
    ev(3'h0, c);
    rd(caddr(c), 8'h80);
    wr(caddr(c), 8'h60);
    ev(3'h1, c);
    rd(caddr(c), 8'h60);
    wr(caddr(c), 8'h80);
    ev(3'h2, c);
    rd(caddr(c), 8'h88);
    @(posedge clk_sys) {isTransmit[c-1], dataUpdated[c-1]} <= 2'b11;
    wr(caddr(c), 8'h80);
    ev(3'h2, c);
    rd(caddr(c), 8'h8D);
    `CHK({remoteAnswerEn[c-1], txPending[c-1]}, 2'b11)
    @(posedge clk_sys) overwriteOrInhibit[c-1] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 `CHK({remoteAnswerEn[c-1], txPending[c-1]}, 2'b00)
    @(posedge clk_sys) overwriteOrInhibit[c-1] <= 1'b0;
    ev(3'h0, c);
    rd(caddr(c), 8'h81);
    wr(caddr(15), 8'hE4);
    ev(3'h0, 15);
    rd(caddr(15), 8'hE0);
    wr(caddr(d), 8'h84);
    wr(caddr(c), 8'h04);
    rd(caddr(d), 8'h84);
    `CHK(txPending[d-1], 1'b1)
    `CHK(centerReady, 15'h4000 | 15'(1) << (d - 1))
    softRst();
    rd(caddr(c), 8'h01);
    rd(caddr(d), 8'h00);
    completeRun();
  end
endmodule : can_err_msg_ctrl_bench
bind can_err_msg_ctrl can_err_msg_ctrl_assertions #(.NCENTER(NCENTER), .RXONLY(RXONLY)) chk_u (
  .clk_sys(clk_sys), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
  .sfrRdata(sfrRdata), .swInitMode(swInitMode), .controllerSoftReset(controllerSoftReset),
  .globalIrqEnable(globalIrqEnable), .txErrUp(txErrUp), .txErrDown(txErrDown), .isTransmit(isTransmit),
  .dataUpdated(dataUpdated), .overwriteOrInhibit(overwriteOrInhibit), .busOff(busOff),
  .errWarning(errWarning), .errPassive(errPassive), .errorCountExceeded(errorCountExceeded),
  .centerReady(centerReady), .txPending(txPending), .remoteAnswerEn(remoteAnswerEn), .canIrq(canIrq));
